// ==== rtl/rtc_pkg.sv ====
// package: register map, bit layout, reset values and states
package rtc_pkg;

    // ************************************************
    // register indices (byte address = 4 * index) and word step
    // ************************************************
    localparam logic [15:0] IDX_CMD   = 16'h0064;
    localparam logic [15:0] IDX_STAT  = 16'h006E;
    localparam logic [15:0] IDX_MODE  = 16'h251C;
    localparam logic [15:0] IDX_LEN   = 16'h2710;
    localparam logic [15:0] IDX_LOOPS = 16'h2724;
    localparam logic [15:0] IDX_SETUP = 16'h0080;
    localparam logic [15:0] IDX_XLEN  = 16'h0081;
    localparam logic [15:0] IDX_CHUNK = 16'h0082;
    localparam logic [15:0] IDX_TMO   = 16'h0083;
    localparam logic [15:0] WORD_STEP = 16'h0004;

    // ************************************************
    // command word bits
    // ************************************************
    localparam int CMD_CARD_START = 2;
    localparam int CMD_CARD_STOP  = 6;
    localparam int CMD_BEGIN      = 16;
    localparam int CMD_WAIT       = 17;
    localparam int CMD_ABORT      = 18;

    // ************************************************
    // status word bits
    // ************************************************
    localparam int ST_BUSY   = 0;
    localparam int ST_REPLAY = 1;
    localparam int ST_VALID  = 2;
    localparam int ST_TMO    = 3;
    localparam int ST_CHUNK  = 8;
    localparam int ST_DONE   = 9;
    localparam int ST_FLOW   = 10;
    localparam int ST_FAULT  = 11;

    // setup register fields
    localparam int SU_DIR  = 0;
    localparam int SU_FIFO = 1;
    localparam int SU_CHL  = 4;

    // ************************************************
    // modes and reset values
    // ************************************************
    localparam logic [31:0] MODE_ONE   = 32'h0000_0100;
    localparam logic [31:0] MODE_PER   = 32'h0000_8000;
    localparam logic [31:0] MODE_RST   = MODE_ONE;
    localparam logic [63:0] LEN_RST    = 64'h0000_0000_0000_0400;
    localparam logic [63:0] LOOPS_RST  = 64'h0000_0000_0000_0001;
    localparam logic [31:0] BYTES_BEAT = 32'h0000_0004;

    typedef enum logic [3:0] {
        REP_IDLE = 4'h1,
        REP_ARM  = 4'h2,
        REP_PLAY = 4'h4,
        REP_GAP  = 4'h8
    } rtc_rep_e;

    typedef enum logic [2:0] {
        XF_IDLE = 3'h1,
        XF_HOLD = 3'h2,
        XF_MOVE = 3'h4
    } rtc_xfer_e;

endpackage

// ==== rtl/rtc_replay_seq.sv ====
// replay sequencer: plays on-board memory after triggers
`timescale 1ns/1ps
module rtc_replay_seq #(
    parameter int SAMPLE_DIV = 4
) (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        start_in,
    input  wire logic        stop_in,
    input  wire logic        trig_in,
    input  wire logic        per_trig_in,
    input  wire logic [63:0] len_in,
    input  wire logic [63:0] loops_in,
    output logic      [63:0] sample_addr_out,
    output logic             sample_stb_out,
    output logic             stop_level_out,
    output logic             running_out
);

    typedef struct packed {
        rtc_pkg::rtc_rep_e st;
        logic [15:0]       div;
        logic [63:0]       addr;
        logic [63:0]       plays;
        logic              stb;
        logic              stoplvl;
        logic              run;
    } rtc_seq_s;

    rtc_seq_s q_r;
    rtc_seq_s q_nxt;

    localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

    // next state: samples leave at a fixed divider, never host-paced
    always_comb begin
        q_nxt = q_r;
        q_nxt.stb = 1'b0;
        unique case (q_r.st)
            rtc_pkg::REP_IDLE: begin
                q_nxt.stoplvl = 1'b1;
                if (start_in && len_in != 64'h0) begin
                    q_nxt.st = rtc_pkg::REP_ARM;
                    q_nxt.plays = 64'h0;
                end
            end
            rtc_pkg::REP_ARM, rtc_pkg::REP_GAP: begin
                q_nxt.stoplvl = 1'b1;
                if (trig_in) begin
                    q_nxt.st = rtc_pkg::REP_PLAY;
                    q_nxt.addr = 64'h0;
                    q_nxt.div = 16'h0;
                end
            end
            rtc_pkg::REP_PLAY: begin
                q_nxt.stoplvl = 1'b0;
                q_nxt.div = q_r.div + 16'h1;
                if (q_r.div == DIV_LAST) begin
                    q_nxt.div = 16'h0;
                    q_nxt.stb = 1'b1;
                    q_nxt.addr = q_r.addr + 64'h1;
                    if (q_r.addr == len_in - 64'h1) begin
                        q_nxt.plays = q_r.plays + 64'h1;
                        q_nxt.addr = 64'h0;
                        // zero loops means run until stopped
                        if (loops_in != 64'h0 && q_nxt.plays >= loops_in) begin
                            q_nxt.st = rtc_pkg::REP_IDLE;
                        end else if (per_trig_in) begin
                            q_nxt.st = rtc_pkg::REP_GAP;
                        end
                    end
                end
            end
            default: q_nxt.st = rtc_pkg::REP_IDLE;
        endcase
        if (stop_in) begin
            q_nxt.st = rtc_pkg::REP_IDLE;
        end
        q_nxt.run = (q_nxt.st != rtc_pkg::REP_IDLE);
        // the last sample of a play still leaves at the play level
        if (q_nxt.st != rtc_pkg::REP_PLAY && !q_nxt.stb) begin
            q_nxt.stoplvl = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            q_r <= '{st: rtc_pkg::REP_IDLE, stoplvl: 1'b1, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sample_addr_out = q_r.addr;
    assign sample_stb_out = q_r.stb;
    assign stop_level_out = q_r.stoplvl;
    assign running_out = q_r.run;

endmodule

// ==== rtl/rtc_replay_transfer_control.sv ====
// top: command/status registers, transfer engine and replay setup
`timescale 1ns/1ps
module rtc_replay_transfer_control #(
    parameter logic [63:0] MEM_SAMPLES = 64'h0000_0000_0100_0000,
    parameter int          SAMPLE_DIV  = 4
) (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [15:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        trig_pin_in,
    output logic             xfer_req_out,
    output logic             xfer_dir_out,
    output logic      [31:0] xfer_addr_out,
    input  wire logic        xfer_ack_in,
    input  wire logic        xfer_err_in,
    input  wire logic        flow_err_in,
    output logic      [63:0] sample_addr_out,
    output logic             sample_stb_out,
    output logic             stop_level_out
);

    // ************************************************
    // byte addresses
    // ************************************************
    localparam logic [15:0] A_CMD   = rtc_pkg::IDX_CMD << 2;
    localparam logic [15:0] A_STAT  = rtc_pkg::IDX_STAT << 2;
    localparam logic [15:0] A_MODE  = rtc_pkg::IDX_MODE << 2;
    localparam logic [15:0] A_LENL  = rtc_pkg::IDX_LEN << 2;
    localparam logic [15:0] A_LENH  = A_LENL + rtc_pkg::WORD_STEP;
    localparam logic [15:0] A_LOOPL = rtc_pkg::IDX_LOOPS << 2;
    localparam logic [15:0] A_LOOPH = A_LOOPL + rtc_pkg::WORD_STEP;
    localparam logic [15:0] A_SETUP = rtc_pkg::IDX_SETUP << 2;
    localparam logic [15:0] A_XLEN  = rtc_pkg::IDX_XLEN << 2;
    localparam logic [15:0] A_CHUNK = rtc_pkg::IDX_CHUNK << 2;
    localparam logic [15:0] A_TMO   = rtc_pkg::IDX_TMO << 2;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic               sy1;
        logic               sy2;
        logic               sy3;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [31:0]        mode;
        logic [63:0]        len;
        logic [63:0]        loops;
        logic               dir;
        logic               fifo;
        logic [2:0]         chl;
        logic [31:0]        xlen;
        logic [31:0]        chunk;
        logic [31:0]        tmo;
        rtc_pkg::rtc_xfer_e xst;
        logic [31:0]        moved;
        logic [31:0]        mark;
        logic               req;
        logic               f_chunk;
        logic               f_done;
        logic               f_flow;
        logic               f_fault;
        logic               f_tmo;
        logic               valid;
        logic               trig_seen;
        logic               waiting;
        logic [31:0]        wcnt;
        logic               card_start;
        logic               card_stop;
    } rtc_top_s;

    rtc_top_s q_r;
    rtc_top_s q_nxt;

    logic        rep_running;
    logic        trig_edge;
    logic        acc;
    logic        first;
    logic        fin;
    logic [63:0] len_max;
    logic [63:0] len_wr;
    logic [31:0] moved_nb;
    logic [31:0] status;

    // trigger edge seen only after two sync stages
    assign trig_edge = q_r.sy2 & ~q_r.sy3;
    assign acc = psel_in & penable_in;
    assign first = acc & ~q_r.pready;
    assign fin = acc & q_r.pready;
    assign len_max = MEM_SAMPLES >> q_r.chl;
    assign moved_nb = q_r.moved + rtc_pkg::BYTES_BEAT;

    // status word image
    always_comb begin
        status = 32'h0;
        status[rtc_pkg::ST_BUSY] = (q_r.xst != rtc_pkg::XF_IDLE);
        status[rtc_pkg::ST_REPLAY] = rep_running;
        status[rtc_pkg::ST_VALID] = q_r.valid;
        status[rtc_pkg::ST_TMO] = q_r.f_tmo;
        status[rtc_pkg::ST_CHUNK] = q_r.f_chunk;
        status[rtc_pkg::ST_DONE] = q_r.f_done;
        status[rtc_pkg::ST_FLOW] = q_r.f_flow;
        status[rtc_pkg::ST_FAULT] = q_r.f_fault;
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        q_nxt = q_r;
        len_wr = 64'h0;
        q_nxt.sy1 = trig_pin_in;
        q_nxt.sy2 = q_r.sy1;
        q_nxt.sy3 = q_r.sy2;
        q_nxt.pready = 1'b0;
        q_nxt.pslverr = 1'b0;
        q_nxt.card_start = 1'b0;
        q_nxt.card_stop = 1'b0;
        if (trig_edge) begin
            q_nxt.trig_seen = 1'b1;
        end

        // read data and error decided in the first access cycle
        if (first && !q_r.waiting) begin
            q_nxt.pready = 1'b1;
            q_nxt.prdata = 32'h0;
            unique case (paddr_in)
                A_CMD:   q_nxt.prdata = 32'h0;
                A_STAT:  q_nxt.prdata = status;
                A_MODE:  q_nxt.prdata = q_r.mode;
                A_LENL:  q_nxt.prdata = q_r.len[31:0];
                A_LENH:  q_nxt.prdata = q_r.len[63:32];
                A_LOOPL: q_nxt.prdata = q_r.loops[31:0];
                A_LOOPH: q_nxt.prdata = q_r.loops[63:32];
                A_SETUP: begin
                    q_nxt.prdata[rtc_pkg::SU_DIR] = q_r.dir;
                    q_nxt.prdata[rtc_pkg::SU_FIFO] = q_r.fifo;
                    q_nxt.prdata[rtc_pkg::SU_CHL +: 3] = q_r.chl;
                end
                A_XLEN:  q_nxt.prdata = q_r.xlen;
                A_CHUNK: q_nxt.prdata = q_r.chunk;
                A_TMO:   q_nxt.prdata = q_r.tmo;
                default: q_nxt.pslverr = 1'b1;
            endcase
            if (pwrite_in && paddr_in == A_STAT) begin
                q_nxt.pslverr = 1'b1;
            end
        end

        // transfer engine
        unique case (q_r.xst)
            rtc_pkg::XF_IDLE: q_nxt.req = 1'b0;
            rtc_pkg::XF_HOLD: begin
                if (q_r.trig_seen) begin
                    q_nxt.xst = rtc_pkg::XF_MOVE;
                    q_nxt.req = 1'b1;
                end
            end
            rtc_pkg::XF_MOVE: begin
                if (xfer_ack_in) begin
                    q_nxt.moved = moved_nb;
                    if (q_r.chunk != 32'h0 && moved_nb >= q_r.mark) begin
                        q_nxt.f_chunk = 1'b1;
                        q_nxt.mark = q_r.mark + q_r.chunk;
                    end
                    if (moved_nb >= q_r.xlen) begin
                        q_nxt.xst = rtc_pkg::XF_IDLE;
                        q_nxt.req = 1'b0;
                        q_nxt.valid = 1'b1;
                        if (q_r.chunk == 32'h0) begin
                            q_nxt.f_done = 1'b1;
                        end
                    end
                end
            end
            default: q_nxt.xst = rtc_pkg::XF_IDLE;
        endcase
        if (q_r.xst != rtc_pkg::XF_IDLE) begin
            if (xfer_err_in) begin
                q_nxt.f_fault = 1'b1;
                q_nxt.xst = rtc_pkg::XF_IDLE;
                q_nxt.req = 1'b0;
                q_nxt.valid = 1'b0;
            end
            if (flow_err_in && q_r.fifo) begin
                q_nxt.f_flow = 1'b1;
            end
        end

        // a status read releases the chunk flag; a new chunk wins
        if (fin && !pwrite_in && paddr_in == A_STAT) begin
            q_nxt.f_chunk = 1'b0;
            if (q_r.xst == rtc_pkg::XF_MOVE && xfer_ack_in && q_r.chunk != 32'h0
                && moved_nb >= q_r.mark) begin
                q_nxt.f_chunk = 1'b1;
            end
        end

        // command word acts in the first access cycle; other bits unused
        if (first && !q_r.waiting && pwrite_in && paddr_in == A_CMD) begin
            if (pwdata_in[rtc_pkg::CMD_CARD_START]) begin
                q_nxt.card_start = 1'b1;
                q_nxt.trig_seen = 1'b0;
            end
            if (pwdata_in[rtc_pkg::CMD_CARD_STOP]) begin
                q_nxt.card_stop = 1'b1;
            end
            if (pwdata_in[rtc_pkg::CMD_BEGIN] && !pwdata_in[rtc_pkg::CMD_ABORT]) begin
                q_nxt.f_chunk = 1'b0;
                q_nxt.f_done = 1'b0;
                q_nxt.f_flow = 1'b0;
                q_nxt.f_fault = 1'b0;
                q_nxt.f_tmo = 1'b0;
                q_nxt.valid = 1'b0;
                q_nxt.moved = 32'h0;
                q_nxt.mark = q_r.chunk;
                if (q_r.xlen == 32'h0) begin
                    // nothing to move: finish at once
                    q_nxt.xst = rtc_pkg::XF_IDLE;
                    q_nxt.valid = 1'b1;
                    q_nxt.f_done = (q_r.chunk == 32'h0);
                end else if (q_r.dir && !q_nxt.trig_seen) begin
                    q_nxt.xst = rtc_pkg::XF_HOLD;
                    q_nxt.req = 1'b0;
                end else begin
                    q_nxt.xst = rtc_pkg::XF_MOVE;
                    q_nxt.req = 1'b1;
                end
            end
            // abort beats a begin in the same write
            if (pwdata_in[rtc_pkg::CMD_ABORT]) begin
                q_nxt.xst = rtc_pkg::XF_IDLE;
                q_nxt.req = 1'b0;
                q_nxt.valid = 1'b0;
            end
            if (pwdata_in[rtc_pkg::CMD_WAIT]) begin
                q_nxt.waiting = 1'b1;
                q_nxt.wcnt = 32'h0;
                q_nxt.pready = 1'b0;
            end
        end

        // wait: hold pready low until end, chunk or timeout
        if (q_r.waiting) begin
            q_nxt.wcnt = q_r.wcnt + 32'h1;
            if (q_r.xst == rtc_pkg::XF_IDLE || q_r.f_chunk) begin
                q_nxt.waiting = 1'b0;
                q_nxt.pready = 1'b1;
            end else if (q_r.tmo != 32'h0 && q_nxt.wcnt >= q_r.tmo) begin
                q_nxt.waiting = 1'b0;
                q_nxt.pready = 1'b1;
                q_nxt.f_tmo = 1'b1;
            end
        end

        // plain register writes land on the completing edge
        if (fin && pwrite_in) begin
            unique case (paddr_in)
                A_MODE: begin
                    // unknown modes are dropped so a read shows the live mode
                    if (pwdata_in == rtc_pkg::MODE_ONE || pwdata_in == rtc_pkg::MODE_PER) begin
                        q_nxt.mode = pwdata_in;
                    end
                end
                A_LENL, A_LENH: begin
                    len_wr = (paddr_in == A_LENL) ? {q_r.len[63:32], pwdata_in}
                                                 : {pwdata_in, q_r.len[31:0]};
                    q_nxt.len = (len_wr > len_max) ? len_max : len_wr;
                end
                A_LOOPL: q_nxt.loops[31:0] = pwdata_in;
                A_LOOPH: q_nxt.loops[63:32] = pwdata_in;
                A_SETUP: begin
                    q_nxt.dir = pwdata_in[rtc_pkg::SU_DIR];
                    q_nxt.fifo = pwdata_in[rtc_pkg::SU_FIFO];
                    q_nxt.chl = pwdata_in[rtc_pkg::SU_CHL +: 3];
                    // fewer samples fit when more channels share memory
                    if (q_r.len > (MEM_SAMPLES >> pwdata_in[rtc_pkg::SU_CHL +: 3])) begin
                        q_nxt.len = MEM_SAMPLES >> pwdata_in[rtc_pkg::SU_CHL +: 3];
                    end
                end
                A_XLEN:  q_nxt.xlen = pwdata_in;
                A_CHUNK: q_nxt.chunk = pwdata_in;
                A_TMO:   q_nxt.tmo = pwdata_in;
                default: q_nxt.xlen = q_r.xlen;
            endcase
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            q_r <= '{xst:   rtc_pkg::XF_IDLE,
                     mode:  rtc_pkg::MODE_RST,
                     len:   rtc_pkg::LEN_RST,
                     loops: rtc_pkg::LOOPS_RST,
                     default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ************************************************
    // replay sequencer
    // ************************************************
    rtc_replay_seq #(
        .SAMPLE_DIV(SAMPLE_DIV)
    ) u_seq (
        .core_clk_in    (core_clk_in),
        .rstn_in        (rstn_in),
        .start_in       (q_r.card_start),
        .stop_in        (q_r.card_stop),
        .trig_in        (trig_edge),
        .per_trig_in    (q_r.mode == rtc_pkg::MODE_PER),
        .len_in         (q_r.len),
        .loops_in       (q_r.loops),
        .sample_addr_out(sample_addr_out),
        .sample_stb_out (sample_stb_out),
        .stop_level_out (stop_level_out),
        .running_out    (rep_running)
    );

    // outputs straight from the state register
    assign prdata_out = q_r.prdata;
    assign pready_out = q_r.pready;
    assign pslverr_out = q_r.pslverr;
    assign xfer_req_out = q_r.req;
    assign xfer_dir_out = q_r.dir;
    assign xfer_addr_out = q_r.moved;

endmodule

// ==== test/rtc_ctl_asserts.sv ====
// checker: port-level properties of the transfer control block
`timescale 1ns/1ps
module rtc_ctl_asserts #(
    parameter int SAMPLE_DIV = 4
) (
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        xfer_req_out,
    input wire logic [31:0] xfer_addr_out,
    input wire logic        xfer_ack_in,
    input wire logic        xfer_err_in,
    input wire logic        sample_stb_out,
    input wire logic        stop_level_out
);
    // ************************************************
    // helpers
    // ************************************************
    logic       cmd_acc;
    logic [7:0] gap_r;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // command word acts on the first access cycle
    assign cmd_acc = psel_in && penable_in && pwrite_in && !pready_out && paddr_in == 16'h0190;
    // cycles since last sample, saturating so long gaps never wrap
    always_ff @(posedge core_clk_in) begin
        gap_r <= (!rstn_in || sample_stb_out) ? 8'h00 : gap_r + {7'h0, gap_r != 8'hFF};
    end
    AST_READY_ONE: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
        else $error("error response without ready");
    AST_STATUS_RO: assert property (psel_in && pwrite_in && paddr_in == 16'h01B8 && pready_out
        |-> pslverr_out) else $error("status write accepted");
    AST_ABORT_HALTS: assert property (cmd_acc && pwdata_in[18] |-> ##[1:2] !xfer_req_out)
        else $error("abort did not halt transfer");
    AST_FAULT_HALTS: assert property (xfer_req_out && xfer_err_in && !cmd_acc
        |-> ##[1:2] !xfer_req_out) else $error("fault did not halt transfer");
    AST_BEAT_STEP: assert property (xfer_req_out && xfer_ack_in && !xfer_err_in && !cmd_acc
        |=> xfer_addr_out == $past(xfer_addr_out) + 32'h0000_0004) else $error("beat offset");
    AST_SAMPLE_SPACING: assert property (sample_stb_out |-> gap_r >= SAMPLE_DIV - 1)
        else $error("samples too close");
    AST_PLAY_LEVEL: assert property (sample_stb_out |-> !stop_level_out)
        else $error("stop level while playing");
endmodule
bind rtc_replay_transfer_control rtc_ctl_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) rtc_ctl_asserts_inst (
    .core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .pslverr_out, .xfer_req_out, .xfer_addr_out, .xfer_ack_in, .xfer_err_in,
    .sample_stb_out, .stop_level_out);

// ==== test/rtc_mem_partner.sv ====
// partner: host memory side taking transfer beats
`timescale 1ns/1ps
module rtc_mem_partner (
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       xfer_req_in,
    input  wire logic [1:0] pace_in,
    output logic            xfer_ack_out
);
    logic tog_r;
    // pace 0 prompt, 1 every other cycle, 2 stalled
    always_ff @(posedge core_clk_in) begin
        tog_r <= rstn_in && !tog_r;
    end
    assign xfer_ack_out = xfer_req_in && (pace_in == 2'h0 || (pace_in == 2'h1 && tog_r));
endmodule

// ==== test/rtc_replay_transfer_control_test.sv ====
// testbench: registers, transfers and replay of the control block
`timescale 1ns/1ps
module rtc_replay_transfer_control_test;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, trig = 0, err = 0, flow = 0;
    logic [15:0] pa = 0;
    logic [31:0] pd = 0, rd, prd, xa;
    logic [1:0]  pace = 0;
    logic        e, pr, pe, rq, ack, stb, sl, dir;
    logic [63:0] sa;
    int          failures = 0, n_checks = 0, nstb = 0, b;
    rtc_replay_transfer_control #(.SAMPLE_DIV(4)) rtc_replay_transfer_control_inst (
        .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(pr), .pslverr_out(pe),
        .trig_pin_in(trig), .xfer_req_out(rq), .xfer_dir_out(dir), .xfer_addr_out(xa),
        .xfer_ack_in(ack), .xfer_err_in(err), .flow_err_in(flow), .sample_addr_out(sa),
        .sample_stb_out(stb), .stop_level_out(sl));
    rtc_mem_partner rtc_mem_partner_inst (
        .core_clk_in(clk), .rstn_in(rstn), .xfer_req_in(rq), .pace_in(pace), .xfer_ack_out(ack));
    // ************************************************
    // clock, sample count, watchdog
    // ************************************************
    initial forever #4 clk = ~clk;
    always @(posedge clk) nstb <= nstb + stb;
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run;
    end
    task complete_run;
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, g, x);
        end
    endtask
    // apb master: holds the request until ready is sampled
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge clk) pen <= 1;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge clk);
        end while (pr !== 1'b1);
        rd = prd;
        e = pe;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task pulse;
        trig <= 1;
        repeat (4) @(posedge clk);
        trig <= 0;
        repeat (80) @(posedge clk);
    endtask
    // length, chunk, command, then status flags
    task xfer(input logic [31:0] len, input logic [31:0] ch, input logic [31:0] c, input logic [31:0] x);
        apb(1, 16'h0204, len);
        apb(1, 16'h0208, ch);
        apb(1, 16'h0190, c);
        apb(0, 16'h01B8, 0);
        chk(rd & 32'hF00, x);
    endtask
    task t_regs;
        apb(0, 16'h9470, 0); chk(rd, 32'h100);
        apb(0, 16'h9C90, 0); chk(rd, 32'h1);
        apb(1, 16'h9470, 32'h8000);
        apb(1, 16'h9470, 32'h1234);
        apb(0, 16'h9470, 0); chk(rd, 32'h8000);
        apb(1, 16'h01B8, 32'hF00); chk({31'h0, e}, 1);
        apb(1, 16'h9C40, 32'h10);
        apb(0, 16'h9C40, 0); chk(rd, 32'h10);
    endtask
    task t_xfer;
        pace <= 1;
        xfer(16, 0, 32'h8003_0000, 32'h200); chk(xa, 16);
        xfer(32, 16, 32'h3_0000, 32'h100);
        pace <= 2;
        apb(1, 16'h020C, 32'h10);
        xfer(4096, 0, 32'h3_0000, 0);
        chk(rd & 32'h8, 32'h8);
        apb(1, 16'h0190, 32'h4_0000);
        apb(0, 16'h01B8, 0); chk(rd & 32'h5, 0);
        xfer(4096, 0, 32'h1_0000, 0);
        err <= 1;
        @(posedge clk) err <= 0;
        apb(0, 16'h01B8, 0); chk(rd & 32'h800, 32'h800);
        apb(1, 16'h0200, 32'h2);
        xfer(4096, 0, 32'h1_0000, 0);
        flow <= 1;
        @(posedge clk) flow <= 0;
        apb(0, 16'h01B8, 0); chk(rd & 32'h400, 32'h400);
        apb(1, 16'h0190, 32'h4_0000);
    endtask
    task t_link;
        pace <= 0;
        apb(1, 16'h0200, 32'h1);
        xfer(16, 0, 32'h1_0004, 0);
        repeat (20) @(posedge clk);
        chk({31'h0, rq}, 0);
        chk({31'h0, dir}, 1);
        trig <= 1;
        repeat (20) @(posedge clk);
        chk(sa[31:0], 4);
        trig <= 0;
        apb(0, 16'h01B8, 0); chk(rd & 32'h202, 32'h202);
        apb(1, 16'h0190, 32'h40);
    endtask
    task t_replay;
        apb(1, 16'h9C40, 4);
        apb(1, 16'h9C90, 2);
        apb(1, 16'h9470, 32'h100);
        apb(1, 16'h0190, 4);
        b = nstb;
        pulse;
        chk(nstb - b, 8);
        apb(1, 16'h9470, 32'h8000);
        apb(1, 16'h0190, 4);
        b = nstb;
        pulse;
        chk(nstb - b, 4);
        chk({31'h0, sl}, 1);
        pulse;
        chk(nstb - b, 8);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        t_regs;
        t_xfer;
        t_link;
        t_replay;
        complete_run;
    end
endmodule
